// [include/dtcc_pkg.sv]
package dtcc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register map
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h88;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h89;
    localparam logic [ADDR_W-1:0] ADDR_TL0  = 8'h8A;
    localparam logic [ADDR_W-1:0] ADDR_TL1  = 8'h8B;
    localparam logic [ADDR_W-1:0] ADDR_TH0  = 8'h8C;
    localparam logic [ADDR_W-1:0] ADDR_TH1  = 8'h8D;

    localparam logic [DATA_W-1:0] CTRL_RESET    = 8'h00;
    localparam logic [DATA_W-1:0] MODE_RESET    = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // control register fields
    localparam int CTRL_TF1 = 7;
    localparam int CTRL_TR1 = 6;
    localparam int CTRL_TF0 = 5;
    localparam int CTRL_TR0 = 4;
    localparam int CTRL_IE1 = 3;
    localparam int CTRL_IT1 = 2;
    localparam int CTRL_IE0 = 1;
    localparam int CTRL_IT0 = 0;

    // mode register fields
    localparam int MODE_TIMER1_PIN_GATING_ENABLE = 7;
    localparam int MODE_CS1   = 6;
    localparam int MODE_T1_HI = 5;
    localparam int MODE_T1_LO = 4;
    localparam int MODE_TIMER0_PIN_GATING_ENABLE = 3;
    localparam int MODE_CS0   = 2;
    localparam int MODE_T0_HI = 1;
    localparam int MODE_T0_LO = 0;

    // counting constants
    localparam logic [4:0]        PRESC_MAX  = 5'h1F;
    localparam logic [4:0]        PRESC_ZERO = 5'h00;
    localparam logic [DATA_W-1:0] BYTE_MAX   = 8'hFF;
    localparam int                STEP_OVF   = 16;
    localparam int                CLK_DIV    = 6;
    localparam int                DIV_W      = 3;
    localparam logic [DIV_W-1:0]  DIV_LAST   = DIV_W'(CLK_DIV - 1);
    localparam logic              PIN_IDLE   = 1'b1;

    typedef enum logic [1:0] {
        MODE_13BIT  = 2'h0,
        MODE_16BIT  = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT  = 2'h3
    } dtcc_mode_t;

endpackage

// [rtl/dtcc_pin_sync.sv]
`timescale 1ns/1ns
module dtcc_pin_sync
    import dtcc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level,
    output logic      fall
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // idle-high reset so release with the pin high never looks like a falling edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_ff <= PIN_IDLE;
            sync_ff <= PIN_IDLE;
            prev_ff <= PIN_IDLE;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign fall  = prev_ff & ~sync_ff;
endmodule

// [rtl/dtcc_clk_div.sv]
`timescale 1ns/1ns
module dtcc_clk_div
    import dtcc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    output logic      tick
);
    logic [DIV_W-1:0] cnt_ff;
    logic             tick_ff;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (cnt_ff == DIV_LAST) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + DIV_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (cnt_ff == DIV_LAST);
        end
    end

    assign tick = tick_ff;
endmodule

// [rtl/dtcc_timer_ctrl.sv]
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module dtcc_timer_ctrl
    import dtcc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWrEn,
    input  wire logic              regRdEn,
    output logic      [DATA_W-1:0] regRdData,
    input  wire logic              extIrq0PinN,
    input  wire logic              extIrq1PinN,
    input  wire logic              timer0CountPin,
    input  wire logic              timer1CountPin,
    input  wire logic              tmr0OvfAck,
    input  wire logic              tmr1OvfAck,
    input  wire logic              extIrq0Ack,
    input  wire logic              extIrq1Ack,
    output logic                   tmr0OvfIrq,
    output logic                   tmr1OvfIrq,
    output logic                   extIrq0Irq,
    output logic                   extIrq1Irq
);
    logic [DATA_W-1:0] ctrl_ff;
    logic [DATA_W-1:0] nxt_ctrl;
    logic [DATA_W-1:0] modeReg_ff;
    logic [DATA_W-1:0] tl0_ff;
    logic [DATA_W-1:0] th0_ff;
    logic [DATA_W-1:0] tl1_ff;
    logic [DATA_W-1:0] th1_ff;
    logic [DATA_W-1:0] rdData_ff;

    logic       divTick;
    logic       irq0Lvl;
    logic       irq0Fall;
    logic       irq1Lvl;
    logic       irq1Fall;
    logic       cnt0Fall;
    logic       cnt1Fall;
    dtcc_mode_t mode0;
    dtcc_mode_t mode1;
    logic       t0Split;
    logic       gateOk0;
    logic       gateOk1;
    logic       src0;
    logic       src1;
    logic       inc0;
    logic       inc1;
    logic       incTh0;
    logic [16:0] step0;
    logic [16:0] step1;
    logic [16:0] stepTh0;
    logic       tf0Set;
    logic       tf1Set;
    logic       wrCtrl;
    logic       wrMode;
    logic       wrTl0;
    logic       wrTh0;
    logic       wrTl1;
    logic       wrTh1;

    dtcc_clk_div u_div (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick    (divTick)
    );

    dtcc_pin_sync u_syncIrq0 (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (extIrq0PinN),
        .level   (irq0Lvl),
        .fall    (irq0Fall)
    );

    dtcc_pin_sync u_syncIrq1 (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (extIrq1PinN),
        .level   (irq1Lvl),
        .fall    (irq1Fall)
    );

    dtcc_pin_sync u_syncCnt0 (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (timer0CountPin),
        .level   (),
        .fall    (cnt0Fall)
    );

    dtcc_pin_sync u_syncCnt1 (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (timer1CountPin),
        .level   (),
        .fall    (cnt1Fall)
    );

    // one count step of a timer pair; bit 16 flags overflow
    function automatic logic [16:0] stepTimer(input dtcc_mode_t mode,
                                              input logic [7:0] th,
                                              input logic [7:0] tl);
        logic [16:0] r;
        r = {1'b0, th, tl};
        case (mode)
            MODE_13BIT: begin
                // upper three low-byte bits ride along untouched
                if (tl[4:0] == PRESC_MAX) begin
                    r = {(th == BYTE_MAX), th + 8'h01, tl[7:5], PRESC_ZERO};
                end else begin
                    r = {1'b0, th, tl[7:5], tl[4:0] + 5'h01};
                end
            end
            MODE_16BIT: begin
                r = {1'b0, th, tl} + 17'h00001;
            end
            MODE_RELOAD: begin
                if (tl == BYTE_MAX) begin
                    r = {1'b1, th, th};
                end else begin
                    r = {1'b0, th, tl + 8'h01};
                end
            end
            default: begin
                r = {(tl == BYTE_MAX), th, tl + 8'h01};
            end
        endcase
        return r;
    endfunction

    // edge mode latches until serviced, level mode follows the pin
    // level mode has no memory, so the flag drops one cycle after the synchronised pin returns high
    function automatic logic extFlagNext(input logic edgeSel,
                                         input logic base,
                                         input logic ack,
                                         input logic fall,
                                         input logic lvl);
        logic r;
        r = ~lvl;
        if (edgeSel) begin
            r = (base & ~ack) | fall;
        end
        return r;
    endfunction

    assign mode0   = dtcc_mode_t'(modeReg_ff[MODE_T0_HI:MODE_T0_LO]);
    assign mode1   = dtcc_mode_t'(modeReg_ff[MODE_T1_HI:MODE_T1_LO]);
    assign t0Split = (mode0 == MODE_SPLIT);

    assign gateOk0 = ~modeReg_ff[MODE_TIMER0_PIN_GATING_ENABLE] | irq0Lvl;
    assign gateOk1 = ~modeReg_ff[MODE_TIMER1_PIN_GATING_ENABLE] | irq1Lvl;
    assign src0    = modeReg_ff[MODE_CS0] ? cnt0Fall : divTick;
    assign src1    = modeReg_ff[MODE_CS1] ? cnt1Fall : divTick;

    assign inc0   = ctrl_ff[CTRL_TR0] & gateOk0 & src0;
    assign incTh0 = t0Split & ctrl_ff[CTRL_TR1] & divTick;
    // with its run bit lent out, timer 1 runs whenever its gate allows and it is not halted
    assign inc1   = (t0Split | ctrl_ff[CTRL_TR1]) & gateOk1 & src1
                    & (mode1 != MODE_SPLIT);

    assign step0   = stepTimer(mode0, th0_ff, tl0_ff);
    assign step1   = stepTimer(mode1, th1_ff, tl1_ff);
    assign stepTh0 = stepTimer(MODE_SPLIT, COUNT_RESET, th0_ff);

    assign tf0Set = inc0 & step0[STEP_OVF];
    assign tf1Set = t0Split ? (incTh0 & stepTh0[STEP_OVF])
                            : (inc1 & step1[STEP_OVF]);

    assign wrCtrl = regWrEn && (regAddr == ADDR_CTRL);
    assign wrMode = regWrEn && (regAddr == ADDR_MODE);
    assign wrTl0  = regWrEn && (regAddr == ADDR_TL0);
    assign wrTh0  = regWrEn && (regAddr == ADDR_TH0);
    assign wrTl1  = regWrEn && (regAddr == ADDR_TL1);
    assign wrTh1  = regWrEn && (regAddr == ADDR_TH1);

    // hardware sets win over software or acknowledge clears
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wrCtrl) begin
            nxt_ctrl = regWrData;
        end
        if (tmr0OvfAck) begin
            nxt_ctrl[CTRL_TF0] = 1'b0;
        end
        if (tf0Set) begin
            nxt_ctrl[CTRL_TF0] = 1'b1;
        end
        if (tmr1OvfAck) begin
            nxt_ctrl[CTRL_TF1] = 1'b0;
        end
        if (tf1Set) begin
            nxt_ctrl[CTRL_TF1] = 1'b1;
        end
        nxt_ctrl[CTRL_IE0] = extFlagNext(ctrl_ff[CTRL_IT0], nxt_ctrl[CTRL_IE0],
                                         extIrq0Ack, irq0Fall, irq0Lvl);
        nxt_ctrl[CTRL_IE1] = extFlagNext(ctrl_ff[CTRL_IT1], nxt_ctrl[CTRL_IE1],
                                         extIrq1Ack, irq1Fall, irq1Lvl);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_ff <= CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            modeReg_ff <= MODE_RESET;
        end else if (wrMode) begin
            modeReg_ff <= regWrData;
        end
    end

    // a software write to a count byte beats a count in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tl0_ff <= COUNT_RESET;
        end else if (wrTl0) begin
            tl0_ff <= regWrData;
        end else if (inc0) begin
            tl0_ff <= step0[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            th0_ff <= COUNT_RESET;
        end else if (wrTh0) begin
            th0_ff <= regWrData;
        end else if (t0Split) begin
            if (incTh0) begin
                th0_ff <= stepTh0[7:0];
            end
        end else if (inc0) begin
            th0_ff <= step0[15:8];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tl1_ff <= COUNT_RESET;
        end else if (wrTl1) begin
            tl1_ff <= regWrData;
        end else if (inc1) begin
            tl1_ff <= step1[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            th1_ff <= COUNT_RESET;
        end else if (wrTh1) begin
            th1_ff <= regWrData;
        end else if (inc1) begin
            th1_ff <= step1[15:8];
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData_ff <= UNMAPPED_READ;
        end else if (!regRdEn) begin
            rdData_ff <= UNMAPPED_READ;
        end else if (regAddr == ADDR_CTRL) begin
            rdData_ff <= ctrl_ff;
        end else if (regAddr == ADDR_MODE) begin
            rdData_ff <= modeReg_ff;
        end else if (regAddr == ADDR_TL0) begin
            rdData_ff <= tl0_ff;
        end else if (regAddr == ADDR_TH0) begin
            rdData_ff <= th0_ff;
        end else if (regAddr == ADDR_TL1) begin
            rdData_ff <= tl1_ff;
        end else if (regAddr == ADDR_TH1) begin
            rdData_ff <= th1_ff;
        end else begin
            rdData_ff <= UNMAPPED_READ;
        end
    end

    assign regRdData  = rdData_ff;
    assign tmr0OvfIrq = ctrl_ff[CTRL_TF0];
    assign tmr1OvfIrq = ctrl_ff[CTRL_TF1];
    assign extIrq0Irq = ctrl_ff[CTRL_IE0];
    assign extIrq1Irq = ctrl_ff[CTRL_IE1];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_gate_blocks;
        (ctrl_ff[CTRL_TR0] && modeReg_ff[MODE_TIMER0_PIN_GATING_ENABLE] && !irq0Lvl && !regWrEn)
            |=> $stable(tl0_ff);
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("gated timer 0 moved");

    property p_counter_waits_pin;
        (ctrl_ff[CTRL_TR0] && modeReg_ff[MODE_CS0] && !cnt0Fall && !regWrEn)
            |=> $stable(tl0_ff);
    endproperty
    a_counter_waits_pin: assert property (p_counter_waits_pin) else $error("counted without fall");

    property p_run_off_holds;
        (!ctrl_ff[CTRL_TR0] && !regWrEn) |=> tl0_ff == $past(tl0_ff);
    endproperty
    a_run_off_holds: assert property (p_run_off_holds) else $error("stopped timer 0 moved");

    property p_presc_keeps_high;
        (inc0 && mode0 == MODE_13BIT && tl0_ff[4:0] != PRESC_MAX && !regWrEn)
            |=> $stable(th0_ff) && tl0_ff[7:5] == $past(tl0_ff[7:5]);
    endproperty
    a_presc_keeps_high: assert property (p_presc_keeps_high) else $error("prescaler leaked");

    property p_split_high_flag;
        (t0Split && ctrl_ff[CTRL_TR1] && divTick && th0_ff == BYTE_MAX) |=> ctrl_ff[CTRL_TF1];
    endproperty
    a_split_high_flag: assert property (p_split_high_flag) else $error("split overflow lost");

    property p_t1_halt;
        (mode1 == MODE_SPLIT && !regWrEn) |=> $stable({th1_ff, tl1_ff});
    endproperty
    a_t1_halt: assert property (p_t1_halt) else $error("halted timer 1 moved");

    property p_t1_flag;
        (inc1 && step1[STEP_OVF] && !t0Split) |=> ctrl_ff[CTRL_TF1];
    endproperty
    a_t1_flag: assert property (p_t1_flag) else $error("timer 1 flag not set");

    property p_t0_flag_ack;
        (ctrl_ff[CTRL_TF0] && tmr0OvfAck && !tf0Set && !wrCtrl) |=> !ctrl_ff[CTRL_TF0];
    endproperty
    a_t0_flag_ack: assert property (p_t0_flag_ack) else $error("timer 0 flag not cleared");

    property p_level_ignores_ack;
        (!ctrl_ff[CTRL_IT1] && !irq1Lvl && extIrq1Ack) |=> ctrl_ff[CTRL_IE1];
    endproperty
    a_level_ignores_ack: assert property (p_level_ignores_ack) else $error("level flag dropped");

    property p_edge_sets;
        (ctrl_ff[CTRL_IT1] && irq1Fall) |=> ctrl_ff[CTRL_IE1];
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge flag not set");

    property p_irq0_level;
        (!ctrl_ff[CTRL_IT0] && !irq0Lvl) |=> ctrl_ff[CTRL_IE0]
            ##1 (ctrl_ff[CTRL_IT0] || ($past(ctrl_ff[CTRL_IT0]))
                 || (ctrl_ff[CTRL_IE0] == !$past(irq0Lvl)));
    endproperty
    a_irq0_level: assert property (p_irq0_level) else $error("level irq 0 missed");

    property p_irq0_edge_ack;
        (ctrl_ff[CTRL_IT0] && extIrq0Ack && !irq0Fall) |=> !ctrl_ff[CTRL_IE0];
    endproperty
    a_irq0_edge_ack: assert property (p_irq0_edge_ack) else $error("edge irq 0 not cleared");

    property p_t1_reload;
        (inc1 && mode1 == MODE_RELOAD && tl1_ff == BYTE_MAX && !regWrEn)
            |=> tl1_ff == $past(th1_ff) && $stable(th1_ff);
    endproperty
    a_t1_reload: assert property (p_t1_reload) else $error("timer 1 reload wrong");

    property p_t0_reload;
        (inc0 && mode0 == MODE_RELOAD && tl0_ff == BYTE_MAX && !regWrEn)
            |=> tl0_ff == $past(th0_ff) && $stable(th0_ff) && ctrl_ff[CTRL_TF0];
    endproperty
    a_t0_reload: assert property (p_t0_reload) else $error("timer 0 reload wrong");

    property p_div_six;
        divTick |=> !divTick [*5] ##1 divTick;
    endproperty
    a_div_six: assert property (p_div_six) else $error("divided clock not six");

    property p_fall_once;
        cnt0Fall |=> !cnt0Fall;
    endproperty
    a_fall_once: assert property (p_fall_once) else $error("fall counted twice");

    property p_cv_split;
        t0Split && tf1Set;
    endproperty
    c_split: cover property (p_cv_split);

    property p_cv_reload;
        inc1 && mode1 == MODE_RELOAD && step1[STEP_OVF];
    endproperty
    c_reload: cover property (p_cv_reload);

    property p_cv_edge;
        ctrl_ff[CTRL_IT0] && irq0Fall ##1 extIrq0Ack;
    endproperty
    c_edge: cover property (p_cv_edge);
endmodule

// [tb/dtcc_pin_model.sv]
`timescale 1ns/1ns
module dtcc_pin_model
    import dtcc_pkg::*;
(
    input  wire logic sys_clk,
    output logic      extIrq0PinN,
    output logic      extIrq1PinN,
    output logic      timer0CountPin,
    output logic      timer1CountPin
);
    // pins rest high, as a pulled-up open-collector line would
    initial begin
        extIrq0PinN    = PIN_IDLE;
        extIrq1PinN    = PIN_IDLE;
        timer0CountPin = PIN_IDLE;
        timer1CountPin = PIN_IDLE;
    end

    task automatic setIrq(input int idx, input logic val);
        @(posedge sys_clk);
        if (idx == 0) begin
            extIrq0PinN <= val;
        end else begin
            extIrq1PinN <= val;
        end
    endtask

    // each level held three cycles so a two-flop synchroniser cannot miss it
    task automatic countFall(input int idx);
        @(posedge sys_clk);
        if (idx == 0) begin
            timer0CountPin <= 1'b0;
        end else begin
            timer1CountPin <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
        if (idx == 0) begin
            timer0CountPin <= 1'b1;
        end else begin
            timer1CountPin <= 1'b1;
        end
        repeat (3) @(posedge sys_clk);
    endtask
endmodule

// [tb/dtcc_timer_ctrl_bench.sv]
`timescale 1ns/1ns
module dtcc_timer_ctrl_bench
    import dtcc_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              rst     = 1'b1;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWrData = 8'h00;
    logic              regWrEn = 1'b0;
    logic              regRdEn = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic              extIrq0PinN, extIrq1PinN, timer0CountPin, timer1CountPin;
    logic [3:0]        ackVec  = 4'h0;
    logic [3:0]        irqVec;
    logic              rdSeen  = 1'b0;
    logic [DATA_W-1:0] expQ[$];
    int                err_count   = 0;
    int                comparisons = 0;
    int                seed        = 4;

    always #5 sys_clk = ~sys_clk;

    dtcc_pin_model pm (
        .sys_clk        (sys_clk),
        .extIrq0PinN    (extIrq0PinN),
        .extIrq1PinN    (extIrq1PinN),
        .timer0CountPin (timer0CountPin),
        .timer1CountPin (timer1CountPin)
    );

    dtcc_timer_ctrl DUT (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .regAddr        (regAddr),
        .regWrData      (regWrData),
        .regWrEn        (regWrEn),
        .regRdEn        (regRdEn),
        .regRdData      (regRdData),
        .extIrq0PinN    (extIrq0PinN),
        .extIrq1PinN    (extIrq1PinN),
        .timer0CountPin (timer0CountPin),
        .timer1CountPin (timer1CountPin),
        .tmr0OvfAck     (ackVec[0]),
        .tmr1OvfAck     (ackVec[1]),
        .extIrq0Ack     (ackVec[2]),
        .extIrq1Ack     (ackVec[3]),
        .tmr0OvfIrq     (irqVec[0]),
        .tmr1OvfIrq     (irqVec[1]),
        .extIrq0Irq     (irqVec[2]),
        .extIrq1Irq     (irqVec[3])
    );

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read data stand only in the cycle after the strobe, so compare there
    always @(posedge sys_clk) begin
        if (rdSeen) begin
            chk(regRdData, expQ.pop_front());
        end
        rdSeen <= regRdEn;
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrEn   <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge sys_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge sys_clk);
        regRdEn <= 1'b0;
    endtask

    task automatic ack(input int idx);
        @(posedge sys_clk);
        ackVec[idx] <= 1'b1;
        @(posedge sys_clk);
        ackVec[idx] <= 1'b0;
    endtask

    // bounded wait; running out counts as a mismatch
    task automatic waitIrq(input int idx, input logic val, input int maxCyc);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < maxCyc && !hit; k++) begin
            @(negedge sys_clk);
            hit = (irqVec[idx] === val);
        end
        chk({7'h00, irqVec[idx]}, {7'h00, val});
    endtask

    task automatic close_out();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // whole run is about 1100 cycles; this is over thirty times that
    initial begin
        #400000;
        err_count++;
        close_out();
    end

    initial begin
        logic [DATA_W-1:0] d;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(ADDR_CTRL + 8'(i), 8'h00);
        end
        wr(8'h90, 8'hFF);
        rd(8'h90, UNMAPPED_READ);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            wr(ADDR_TH1, d);
            rd(ADDR_TH1, d);
            wr(ADDR_MODE, d);
            rd(ADDR_MODE, d);
        end
        wr(ADDR_MODE, 8'h00);
        $display("test registers done");
        // mode 1 carry into high byte, overflow flag and its clear
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_TL0, 8'hFF);
        wr(ADDR_TH0, 8'hFF);
        wr(ADDR_CTRL, 8'h10);
        waitIrq(0, 1'b1, 20);
        rd(ADDR_TH0, 8'h00);
        ack(0);
        waitIrq(0, 1'b0, 3);
        wr(ADDR_CTRL, 8'h00);
        $display("test timer0 cascade done");
        // mode 2 reload: second overflow must come after 128 ticks, not 256
        wr(ADDR_MODE, 8'h20);
        wr(ADDR_TH1, 8'h80);
        wr(ADDR_TL1, 8'hFF);
        wr(ADDR_CTRL, 8'h40);
        waitIrq(1, 1'b1, 20);
        rd(ADDR_TH1, 8'h80);
        ack(1);
        waitIrq(1, 1'b0, 3);
        waitIrq(1, 1'b1, 800);
        wr(ADDR_CTRL, 8'h00);
        ack(1);
        $display("test timer1 reload done");
        // counter mode 0: only pin falls count, prescaler spills into high byte
        wr(ADDR_MODE, 8'h04);
        wr(ADDR_TL0, 8'hFF);
        wr(ADDR_TH0, 8'h05);
        wr(ADDR_CTRL, 8'h10);
        repeat (20) @(posedge sys_clk);
        rd(ADDR_TL0, 8'hFF);
        pm.countFall(0);
        rd(ADDR_TL0, 8'hE0);
        rd(ADDR_TH0, 8'h06);
        wr(ADDR_CTRL, 8'h00);
        $display("test counter mode done");
        // timer 1 halt in mode 3 despite run bit
        wr(ADDR_MODE, 8'h30);
        wr(ADDR_TL1, 8'h42);
        wr(ADDR_CTRL, 8'h40);
        repeat (30) @(posedge sys_clk);
        rd(ADDR_TL1, 8'h42);
        wr(ADDR_CTRL, 8'h00);
        $display("test halt done");
        // split mode: high byte counts clk/6 under timer 1 run bit and flag
        wr(ADDR_MODE, 8'h03);
        wr(ADDR_TH0, 8'hFE);
        wr(ADDR_CTRL, 8'h40);
        waitIrq(1, 1'b1, 20);
        chk({7'h00, irqVec[0]}, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        ack(1);
        $display("test split done");
        // gating by interrupt 0 pin level
        wr(ADDR_MODE, 8'h09);
        wr(ADDR_TL0, 8'hFF);
        wr(ADDR_TH0, 8'hFF);
        pm.setIrq(0, 1'b0);
        wr(ADDR_CTRL, 8'h10);
        repeat (30) @(posedge sys_clk);
        rd(ADDR_TL0, 8'hFF);
        pm.setIrq(0, 1'b1);
        waitIrq(0, 1'b1, 20);
        wr(ADDR_CTRL, 8'h00);
        ack(0);
        wr(ADDR_MODE, 8'h00);
        $display("test gate done");
        // external interrupts, edge then level, both pins
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL, (i == 0) ? 8'h01 : 8'h04);
            rd(ADDR_CTRL, (i == 0) ? 8'h01 : 8'h04);
            pm.setIrq(i, 1'b0);
            repeat (2) @(posedge sys_clk);
            pm.setIrq(i, 1'b1);
            waitIrq(2 + i, 1'b1, 10);
            repeat (5) @(posedge sys_clk);
            chk({7'h00, irqVec[2 + i]}, 8'h01);
            ack(2 + i);
            waitIrq(2 + i, 1'b0, 3);
            wr(ADDR_CTRL, 8'h00);
            pm.setIrq(i, 1'b0);
            waitIrq(2 + i, 1'b1, 10);
            ack(2 + i);
            repeat (2) @(posedge sys_clk);
            chk({7'h00, irqVec[2 + i]}, 8'h01);
            pm.setIrq(i, 1'b1);
            waitIrq(2 + i, 1'b0, 6);
        end
        $display("test external interrupts done");
        repeat (3) @(posedge sys_clk);
        close_out();
    end
endmodule
